// >>> rtl/dimmer_local_control.sv
`timescale 1ns/100ps
`default_nettype none
module dimmer_local_control
    import dimmer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Front panel knobs and switches
    input  wire logic [3:0]         chan_select,
    input  wire logic [3:0]         level_knob,
    input  wire logic [7:0]         config_sw,
    // Heat sink temperatures in degrees
    input  wire logic [7:0]         sink0_temp,
    input  wire logic [7:0]         sink1_temp,
    // Breaker trip sense per channel
    input  wire logic [NUM_CH-1:0]  branch_breaker_trip,
    // Channel drive levels, flattened
    output var  logic [NUM_CH*8-1:0] chan_level,
    // Channel indicator LEDs
    output var  logic [NUM_CH-1:0]  chan_led,
    // Monitoring outputs
    output var  logic               overtemp_relay,
    output var  logic               fan0_pwm,
    output var  logic               fan1_pwm
);
    import dimmer_pkg::*;

    // Synchronised panel inputs
    logic [3:0]        sel_s;
    logic [3:0]        knob_s;
    logic [7:0]        sw_s;
    logic [7:0]        t0_s;
    logic [7:0]        t1_s;
    logic [NUM_CH-1:0] brk_s;

    dimmer_sync #(.W(44)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({chan_select, level_knob, config_sw, sink0_temp, sink1_temp,
                    branch_breaker_trip}),
        .sync_out ({sel_s, knob_s, sw_s, t0_s, t1_s, brk_s})
    );

    // Per-sink fans
    dimmer_fan u_fan0 (.core_clk(core_clk), .rst_n(rst_n), .temp(t0_s), .fan_pwm(fan0_pwm));
    dimmer_fan u_fan1 (.core_clk(core_clk), .rst_n(rst_n), .temp(t1_s), .fan_pwm(fan1_pwm));

    // Timebase state
    logic [31:0]       tick_cnt_q;   // Cycles toward next tick
    logic [31:0]       tick_cnt_d;
    logic              tick;         // One-cycle tick pulse
    logic [9:0]        flash_q;      // Double-flash frame phase
    logic [9:0]        flash_d;

    // Ramp and chase state
    logic [LVL_W-1:0]  ramp_q;       // Ramp fade level
    logic [LVL_W-1:0]  ramp_d;
    logic [7:0]        ramp_div_q;   // Ticks since last ramp step
    logic [7:0]        ramp_div_d;
    logic [7:0]        ramp_period;  // Ticks per ramp step
    logic [3:0]        step_q;       // Chase step index
    logic [3:0]        step_d;
    logic [9:0]        chase_div_q;  // Ticks since last chase step
    logic [9:0]        chase_div_d;
    logic [9:0]        chase_period; // Ticks per chase step
    logic [7:0]        sweep_q;      // Chase speed sweep for ramp positions
    logic [7:0]        sweep_d;
    logic [11:0]       lfsr_q;       // Random source for chase C
    logic [11:0]       lfsr_d;
    logic [3:0]        rand_ch_q;    // Randomly chosen channel
    logic [3:0]        rand_ch_d;

    // Scene and protection state
    logic [LVL_W-1:0]  scene_q [NUM_CH];  // Latched scene, volatile
    logic [LVL_W-1:0]  scene_d [NUM_CH];
    logic              ot_q;             // Over-temperature condition
    logic              ot_d;

    // Knob decode
    logic              knob_ramp;        // Knob on a ramp position
    logic [LVL_W-1:0]  knob_level;       // Dialled level
    logic              latch_on;
    logic              chase_on;
    logic [LVL_W-1:0]  lvl_d [NUM_CH];
    logic [NUM_CH-1:0] led_d;
    logic [NUM_CH-1:0] chase_mask;
    logic              flash_lit;

    // Tick generator and double-flash phase
    always_comb begin
        tick       = (tick_cnt_q == 32'(TICK_CYCLES - 1));
        tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
        flash_d    = flash_q;
        if (tick) begin
            flash_d = (flash_q == FLASH_FRAME) ? 10'h000 : flash_q + 10'h001;
        end
        flash_lit = ((flash_q >= FLASH_ON1) && (flash_q < FLASH_ON1 + FLASH_LEN)) ||
                    ((flash_q >= FLASH_ON2) && (flash_q < FLASH_ON2 + FLASH_LEN));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            flash_q    <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            flash_q    <= flash_d;
        end
    end

    // Knob decode: tenths scaled to 0..255, ramps select a fade speed
    always_comb begin
        knob_ramp  = (level_knob_ramp(knob_s));
        knob_level = knob_ramp ? 8'h00
                   : (knob_s >= KNOB_FULL) ? LVL_FULL
                   : 8'((12'(knob_s) * 12'd255) / 12'd10);
        ramp_period = 8'h02 << 2'(knob_s - KNOB_RAMP0);
        latch_on   = sw_s[SW_LATCH_BIT];
        chase_on   = (sel_s >= SEL_CHASE_A);
    end

    // True on any of the four ramp positions
    function automatic logic level_knob_ramp(input logic [3:0] k);
        level_knob_ramp = (k >= KNOB_RAMP0) && (k <= KNOB_RAMP3);
    endfunction

    // Ramp fade and chase sequencing
    always_comb begin
        ramp_d      = ramp_q;
        ramp_div_d  = ramp_div_q;
        step_d      = step_q;
        chase_div_d = chase_div_q;
        sweep_d     = sweep_q;
        lfsr_d      = {lfsr_q[10:0], lfsr_q[11] ^ lfsr_q[10] ^ lfsr_q[9] ^ lfsr_q[3]};
        rand_ch_d   = rand_ch_q;
        // Slow ramp: longer step period at higher ramp positions
        if (!knob_ramp) begin
            ramp_d     = 8'h00;
            ramp_div_d = 8'h00;
        end else if (tick) begin
            if (ramp_div_q >= ramp_period) begin
                ramp_div_d = 8'h00;
                ramp_d     = (ramp_q == LVL_FULL) ? 8'h00 : ramp_q + 8'h01;
                if (knob_ramp && chase_on) begin
                    sweep_d = (sweep_q == 8'hff) ? 8'h00 : sweep_q + 8'h01;
                end
            end else begin
                ramp_div_d = ramp_div_q + 8'h01;
            end
        end
        // Chase period: knob sets speed, ramp positions sweep it
        if (knob_ramp) begin
            chase_period = 10'h3ff - {sweep_q, 2'b00};
        end else begin
            chase_period = 10'h3ff - {2'b00, knob_level};
        end
        if (!chase_on) begin
            step_d      = 4'h0;
            chase_div_d = 10'h000;
        end else if ((sel_s == SEL_CHASE_B) && (step_q >= 4'(CHASE_B_STEPS))) begin
            // Entering the short pattern from a longer one: restart at group one
            step_d      = 4'h0;
        end else if (tick) begin
            if (chase_div_q >= chase_period) begin
                chase_div_d = 10'h000;
                if (sel_s == SEL_CHASE_B) begin
                    step_d = (step_q >= 4'(CHASE_B_STEPS - 1)) ? 4'h0 : step_q + 4'h1;
                end else begin
                    step_d = (step_q >= 4'(NUM_CH - 1)) ? 4'h0 : step_q + 4'h1;
                end
                // Pick a fresh random channel in range
                rand_ch_d = (lfsr_q[3:0] >= 4'(NUM_CH)) ? lfsr_q[3:0] - 4'(NUM_CH)
                                                        : lfsr_q[3:0];
            end else begin
                chase_div_d = chase_div_q + 10'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_q      <= '0;
            ramp_div_q  <= '0;
            step_q      <= '0;
            chase_div_q <= '0;
            sweep_q     <= '0;
            lfsr_q      <= 12'h001;
            rand_ch_q   <= '0;
        end else begin
            ramp_q      <= ramp_d;
            ramp_div_q  <= ramp_div_d;
            step_q      <= step_d;
            chase_div_q <= chase_div_d;
            sweep_q     <= sweep_d;
            lfsr_q      <= lfsr_d;
            rand_ch_q   <= rand_ch_d;
        end
    end

    // Over-temperature with hysteresis
    always_comb begin
        ot_d = ot_q;
        if ((t0_s >= TEMP_TRIP) || (t1_s >= TEMP_TRIP)) begin
            ot_d = 1'b1;
        end else if ((t0_s <= TEMP_CLEAR) && (t1_s <= TEMP_CLEAR)) begin
            ot_d = 1'b0;
        end
    end

    // Per-channel level, scene and LED logic
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            logic [LVL_W-1:0] live;   // Level of this channel from knobs
            logic             hit;    // Selector addresses this channel
            always_comb begin
                hit  = (sel_s == 4'(gi)) || (sel_s == SEL_ALL);
                live = knob_ramp ? ramp_q : knob_level;
                // Scene updates only for the selected channel
                scene_d[gi] = scene_q[gi];
                if (latch_on && !chase_on && hit) begin
                    scene_d[gi] = live;
                end
                // Chase mask for this channel
                unique case (sel_s)
                    SEL_CHASE_A: chase_mask[gi] = (step_q == 4'(gi));
                    SEL_CHASE_B: chase_mask[gi] = (step_q == 4'(gi / 3));
                    SEL_CHASE_C: chase_mask[gi] = (rand_ch_q == 4'(gi));
                    default:     chase_mask[gi] = 1'b0;
                endcase
                if (ot_q) begin
                    lvl_d[gi] = 8'h00;
                end else if (chase_on) begin
                    lvl_d[gi] = chase_mask[gi] ? LVL_FULL : 8'h00;
                end else if (latch_on) begin
                    lvl_d[gi] = scene_q[gi];
                end else if (hit) begin
                    lvl_d[gi] = live;
                end else begin
                    lvl_d[gi] = 8'h00;
                end
                // LED: double flash on trip, else mimic drive level
                if (brk_s[gi]) begin
                    led_d[gi] = flash_lit;
                end else begin
                    led_d[gi] = (lvl_d[gi] > flash_q[9:2]);
                end
            end
            // Volatile scene store: cleared only by rst_n reset
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    scene_q[gi] <= '0;
                end else begin
                    scene_q[gi] <= scene_d[gi];
                end
            end
            // Registered drive output
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    chan_level[gi*8 +: 8] <= '0;
                    chan_led[gi]          <= 1'b0;
                end else begin
                    chan_level[gi*8 +: 8] <= lvl_d[gi];
                    chan_led[gi]          <= led_d[gi];
                end
            end
        end
    endgenerate

    // Protection state and relay
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ot_q           <= 1'b0;
            overtemp_relay <= 1'b0;
        end else begin
            ot_q           <= ot_d;
            overtemp_relay <= ot_d;
        end
    end

    // Assertions
    // Protection checks
    ot_blank_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ot_q |=> (chan_level == '0))
        else $error("output live during over-temperature");
    relay_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        overtemp_relay == ot_q)
        else $error("relay differs from condition");
    trip_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (t0_s >= TEMP_TRIP) |=> ot_q)
        else $error("no trip at threshold");
    hold_hyst_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ot_q && (t0_s > TEMP_CLEAR)) |=> ot_q)
        else $error("cleared above recovery");

    // Manual, ramp, scene and breaker LED checks
    latch_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!latch_on && !chase_on && !ot_q && (sel_s == 4'h0)) |=> (chan_level[95:88] == 8'h00))
        else $error("unselected channel driven");
    all_chan_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((sel_s == SEL_ALL) && !ot_q && !latch_on && !knob_ramp)
            |=> (chan_level[95:88] == $past(knob_level)))
        else $error("all position missed last channel");
    ramp_snap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (knob_ramp && tick && (ramp_div_q >= ramp_period) && (ramp_q == LVL_FULL))
            |=> (ramp_q == 8'h00))
        else $error("ramp did not snap to zero");
    scene_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!latch_on) |=> $stable(scene_q[0]))
        else $error("scene changed while latch off");
    scene_led_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (latch_on && !chase_on && !ot_q && !brk_s[0] && (scene_q[0] == LVL_FULL))
            |=> chan_led[0])
        else $error("full scene channel LED dark");
    flash_led_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        brk_s[0] |=> (chan_led[0] == $past(flash_lit)))
        else $error("tripped channel LED off pattern");

    // Chase checks
    chase_a_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sel_s == SEL_CHASE_A) |-> ($countones(chase_mask) == 1))
        else $error("chase A not one channel");
    chase_b_grp_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((sel_s == SEL_CHASE_B) && ($past(sel_s) == SEL_CHASE_B))
            |-> ($countones(chase_mask) == 3))
        else $error("chase B group size");
    chase_c_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sel_s == SEL_CHASE_C) |-> ($countones(chase_mask) == 1))
        else $error("chase C not one channel");
    sweep_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (knob_ramp && chase_on && tick && (ramp_div_q >= ramp_period) && (sweep_q == 8'hff))
            |=> (sweep_q == 8'h00))
        else $error("chase sweep did not wrap");
endmodule
`default_nettype wire

// >>> rtl/dimmer_pkg.sv
package dimmer_pkg;
    // Channel count and level width
    localparam int          NUM_CH       = 12;
    localparam int          LVL_W        = 8;
    localparam logic [7:0]  LVL_FULL     = 8'hff;
    // Channel selector positions: 0..11 single, 12 all, 13..15 chases A..C
    localparam logic [3:0]  SEL_ALL      = 4'hc;
    localparam logic [3:0]  SEL_CHASE_A  = 4'hd;
    localparam logic [3:0]  SEL_CHASE_B  = 4'he;
    localparam logic [3:0]  SEL_CHASE_C  = 4'hf;
    // Level knob positions: 0..10 tenths, 11..14 ramps 1..4
    localparam logic [3:0]  KNOB_FULL    = 4'ha;
    localparam logic [3:0]  KNOB_RAMP0   = 4'hb;
    localparam logic [3:0]  KNOB_RAMP3   = 4'he;
    // Latch enable bit position within the configuration switch bank
    localparam int          SW_LATCH_BIT = 6;
    // Chase B has four groups of three channels
    localparam int          CHASE_B_STEPS = 4;
    // Temperature thresholds in degrees
    localparam logic [7:0]  TEMP_TRIP    = 8'd105;
    localparam logic [7:0]  TEMP_CLEAR   = 8'd80;
    localparam logic [7:0]  TEMP_FAN_LO  = 8'd40;
    // Tick of the ramp and chase timebase: 1 ms at 200 MHz
    localparam int          CLK_MHZ      = 200;
    localparam int          TICK_US      = 1000;
    localparam int          TICK_CYC     = TICK_US * CLK_MHZ;
    // Breaker double-flash frame in ticks and its two on windows
    localparam logic [9:0]  FLASH_FRAME  = 10'h3e7;
    localparam logic [9:0]  FLASH_ON1    = 10'h064;
    localparam logic [9:0]  FLASH_ON2    = 10'h12c;
    localparam logic [9:0]  FLASH_LEN    = 10'h064;
endpackage

// >>> rtl/dimmer_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin levels
module dimmer_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;     // First stage, read only by second
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    // Next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dimmer_fan.sv
`timescale 1ns/100ps
`default_nettype none
// Fan PWM for one heat sink: duty rises with temperature
module dimmer_fan
    import dimmer_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Heat sink temperature, synchronised
    input  wire logic [7:0] temp,
    // Fan drive
    output var  logic       fan_pwm
);
    logic [7:0] cnt_q;        // PWM phase
    logic [7:0] cnt_d;
    logic [7:0] duty;         // Duty from temperature
    logic       pwm_d;

    // Duty grows linearly above the low threshold
    always_comb begin
        cnt_d = cnt_q + 8'h01;
        if (temp <= TEMP_FAN_LO) begin
            duty = 8'h20;
        end else if (temp >= TEMP_TRIP) begin
            duty = 8'hff;
        end else begin
            // Slope of three per degree keeps the sum below 8'hff, so no wrap
            duty = 8'h20 + 8'((temp - TEMP_FAN_LO) * 8'd3);
        end
        pwm_d = (cnt_q < duty);
    end

    // Register phase and output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            fan_pwm <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            fan_pwm <= pwm_d;
        end
    end
endmodule
`default_nettype wire

// >>> verification/panel_model.sv
`timescale 1ns/100ps
`default_nettype none
// Operator at the front panel: knobs, switches, sink heat and breakers
module panel_model (
    // Clock
    input  wire logic        core_clk,
    // Panel controls seen by the dimmer
    output var  logic [3:0]  chan_select = 4'h0,
    output var  logic [3:0]  level_knob = 4'h0,
    output var  logic [7:0]  config_sw = 8'h00,
    output var  logic [7:0]  sink0_temp = 8'h19,
    output var  logic [7:0]  sink1_temp = 8'h19,
    output var  logic [11:0] branch_breaker_trip = 12'h000
);
    // Positions the operator turns to at the next falling edge
    logic [3:0]  sel_n = 4'h0;
    logic [3:0]  knob_n = 4'h0;
    logic [7:0]  sw_n = 8'h00;
    logic [7:0]  t0_n = 8'h19;
    logic [7:0]  t1_n = 8'h19;
    logic [11:0] trip_n = 12'h000;
    // Controls only move at the falling edge, away from sampling
    always @(negedge core_clk) begin
        chan_select <= sel_n;
        level_knob <= knob_n;
        config_sw <= sw_n;
        sink0_temp <= t0_n;
        sink1_temp <= t1_n;
        branch_breaker_trip <= trip_n;
    end
    // Queue a new panel setting
    task set_panel(input logic [3:0] s, k, input logic [7:0] w, a, b, input logic [11:0] tr);
        {sel_n, knob_n, sw_n, t0_n, t1_n, trip_n} = {s, k, w, a, b, tr};
    endtask
endmodule
`default_nettype wire

// >>> verification/dimmer_local_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the front-panel control block
module dimmer_local_control_tb;
    import dimmer_pkg::*;
    // Clock, reset and pins
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    wire logic [3:0]  sel_w, knob_w;
    wire logic [7:0]  sw_w, t0_w, t1_w;
    wire logic [11:0] trip_w;
    logic [95:0]      chan_level;
    logic [11:0]      chan_led;
    logic             relay, fan0, fan1;
    // Counters and bench model state
    int          bad_count = 0;
    int          n_tests = 0;
    int          seed = 32'h7c85;
    int          scene[12];
    int          sel, knob, sw, t, i, k, sh, prev_t, hi0, hi1, f0, f1, rises;
    bit          ot = 1'b0;
    logic [11:0] m, pm, seen;

    // 200 MHz clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    dimmer_local_control #(.TICK_CYCLES(1)) dimmer_local_control_i (
        .core_clk(core_clk), .rst_n(rst_n), .chan_select(sel_w), .level_knob(knob_w),
        .config_sw(sw_w), .sink0_temp(t0_w), .sink1_temp(t1_w),
        .branch_breaker_trip(trip_w), .chan_level(chan_level), .chan_led(chan_led),
        .overtemp_relay(relay), .fan0_pwm(fan0), .fan1_pwm(fan1));
    panel_model panel_model_i (
        .core_clk(core_clk), .chan_select(sel_w), .level_knob(knob_w), .config_sw(sw_w),
        .sink0_temp(t0_w), .sink1_temp(t1_w), .branch_breaker_trip(trip_w));

    // Closing report
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Step past a falling edge, so outputs are settled
    task tick;
        @(negedge core_clk);
        #1;
    endtask
    // Compare a single value
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Knob position to drive level
    function int lvl(int kn);
        return kn * 255 / 10;
    endfunction
    // Expected channel levels from the model
    function logic [95:0] exp_lv();
        logic [95:0] v;
        v = '0;
        for (int c = 0; c < 12; c++) begin
            if (ot) v[c*8+:8] = 8'h00;
            else if (sw[6]) v[c*8+:8] = scene[c];
            else if (sel == 12 || sel == c) v[c*8+:8] = lvl(knob);
        end
        return v;
    endfunction
    // Compare all channel levels
    task chk_lv;
        n_tests++;
        if (chan_level !== exp_lv()) begin
            bad_count++;
            $display("CHECK FAILED chan_level expected %h seen %h", exp_lv(), chan_level);
        end
    endtask
    // Lit channels
    function logic [11:0] mask();
        for (int c = 0; c < 12; c++) mask[c] = |chan_level[c*8+:8];
    endfunction
    // Set the panel, let it settle, update the model
    task set_p(input int s, kn, w, a, b, tr);
        {sel, knob, sw} = {s, kn, w};
        panel_model_i.set_panel(s[3:0], kn[3:0], w[7:0], a[7:0], b[7:0], tr[11:0]);
        repeat (8) tick;
        if (a >= 105 || b >= 105) ot = 1'b1;
        else if (a <= 80 && b <= 80) ot = 1'b0;
        for (int c = 0; c < 12; c++)
            if (w[6] && !ot && (s == 12 || s == c)) scene[c] = lvl(kn);
    endtask
    // Hung wait: count it and close
    task hang;
        chk("wait", 1, 0);
        give_verdict;
    endtask
    // Wait for the lit pattern to move on
    task wait_chg;
        for (t = 0; t < 2000 && mask() === pm; t++) tick;
        if (mask() === pm) hang;
    endtask
    // Watch LEDs a, b and both fans for n cycles
    task watch(input int n, a, b);
        logic pv;
        {hi0, hi1, f0, f1, rises} = 0;
        pv = chan_led[a];
        for (t = 0; t < n; t++) begin
            tick;
            if (chan_led[a] === 1'b1 && pv === 1'b0) rises++;
            pv = chan_led[a];
            hi0 += (chan_led[a] === 1'b1);
            hi1 += (chan_led[b] === 1'b1);
            f0 += (fan0 === 1'b1);
            f1 += (fan1 === 1'b1);
        end
    endtask

    // Main sequence
    initial begin
        foreach (scene[c]) scene[c] = 0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        tick;
        chk("relay", 0, relay);
        // Every knob step on a random channel, then all channels
        for (k = 0; k <= 10; k++) begin
            set_p({$random(seed)} % 12, k, 0, 25, 25, 0);
            chk_lv;
        end
        set_p(12, 5, 0, 25, 25, 0);
        chk_lv;
        // Scene built channel by channel
        for (i = 0; i < 12; i++) begin
            set_p(i, {$random(seed)} % 11, 8'h40, 25, 25, 0);
            chk_lv;
        end
        set_p(0, 10, 8'h40, 25, 25, 0);
        set_p(1, 0, 8'h40, 25, 25, 0);
        watch(300, 0, 1);
        chk("led full", 1, hi0 > 0);
        chk("led zero", 0, hi1);
        // Switch 7 off blanks the scene, on restores it
        set_p(1, 0, 0, 25, 25, 0);
        chk_lv;
        set_p(1, 0, 8'h40, 25, 25, 0);
        chk_lv;
        // Reset loses the scene
        rst_n = 1'b0;
        repeat (3) tick;
        rst_n = 1'b1;
        foreach (scene[c]) scene[c] = 0;
        set_p(1, 0, 8'h40, 25, 25, 0);
        chk_lv;
        // Four ramps, each slower than the last
        for (k = 11; k <= 14; k++) begin
            set_p(0, k, 0, 25, 25, 0);
            for (t = 0; t < 9000 && chan_level[7:0] !== 8'h00; t++) tick;
            for (t = 0; t < 9000 && chan_level[7:0] !== 8'hff; t++) tick;
            if (t >= 9000) hang;
            prev_t = (k == 11) ? 0 : prev_t;
            if (k > 11) chk("ramp time", 1, t > prev_t * 3 / 2);
            prev_t = t;
            for (t = 0; t < 50 && chan_level[7:0] === 8'hff; t++) tick;
            chk("ramp snap", 8'h00, chan_level[7:0]);
        end
        // Chases A and B step in order
        for (k = 0; k < 2; k++) begin
            sh = k ? 3 : 1;
            set_p(13 + k, 10, 0, 25, 25, 0);
            pm = mask();
            wait_chg;
            m = mask();
            chk("chase width", k ? 3 : 1, $countones(m));
            for (i = 0; i < (k ? 4 : 12); i++) begin
                pm = m;
                wait_chg;
                m = (pm << sh) | (pm >> (12 - sh));
                chk("chase step", m, mask());
                m = mask();
            end
        end
        // Ramp position speeds the chase up: a step shorter than the one before
        set_p(13, 11, 0, 25, 25, 0);
        pm = mask();
        wait_chg;
        pm = mask();
        wait_chg;
        prev_t = t;
        pm = mask();
        wait_chg;
        chk("chase sweep", 1, t < prev_t);
        // Random chase reaches every channel
        set_p(15, 10, 0, 25, 25, 0);
        seen = 12'h000;
        for (t = 0; t < 50000; t++) begin
            seen |= mask();
            tick;
        end
        chk("random chase", 12'hfff, seen);
        // Over-temperature trip, hold and clear
        set_p(12, 10, 0, 104, 25, 0);
        chk("relay", 0, relay);
        set_p(12, 10, 0, 25, 105, 0);
        chk("relay", 1, relay);
        chk_lv;
        set_p(12, 10, 0, 80, 81, 0);
        chk("relay", 1, relay);
        chk_lv;
        set_p(12, 10, 0, 80, 80, 0);
        chk("relay", 0, relay);
        chk_lv;
        // Each fan follows its own sink
        set_p(12, 0, 0, 100, 30, 0);
        watch(2048, 0, 1);
        chk("fan0 faster", 1, f0 > f1);
        set_p(12, 0, 0, 30, 100, 0);
        watch(2048, 0, 1);
        chk("fan1 faster", 1, f1 > f0);
        // Tripped breaker double-flashes its LED
        set_p(2, 10, 0, 25, 25, 12'h004);
        watch(1000, 2, 0);
        chk("flash count", 2, rises);
        give_verdict;
    end
endmodule
`default_nettype wire
